//--- rtl/bsbx_regs.vh
// Constants for the bit, stack and branch execution slice
`ifndef BSBX_REGS_VH
`define BSBX_REGS_VH
// Operation codes
`define BSBX_OP_CLR_C 5'h00
`define BSBX_OP_SET_C 5'h01
`define BSBX_OP_CPL_C 5'h02
`define BSBX_OP_CLR_B 5'h03
`define BSBX_OP_SET_B 5'h04
`define BSBX_OP_CPL_B 5'h05
`define BSBX_OP_ANL 5'h06
`define BSBX_OP_ANL_N 5'h07
`define BSBX_OP_ORL 5'h08
`define BSBX_OP_ORL_N 5'h09
`define BSBX_OP_MOV_CB 5'h0a
`define BSBX_OP_MOV_BC 5'h0b
`define BSBX_OP_XCH 5'h0c
`define BSBX_OP_NIBBLE_SWAP_OP 5'h0d
`define BSBX_OP_PUSH 5'h0e
`define BSBX_OP_POP 5'h0f
`define BSBX_OP_BR 5'h10
// Operand forms
`define BSBX_F_SHORT 3'h0
`define BSBX_F_LONG 3'h1
`define BSBX_F_REG 3'h0
`define BSBX_F_DIR 3'h1
`define BSBX_F_IND 3'h2
`define BSBX_F_SDIR 3'h0
`define BSBX_F_IMM8 3'h1
`define BSBX_F_IMM16 3'h2
`define BSBX_F_BYTE 3'h3
`define BSBX_F_WORD 3'h4
`define BSBX_F_DWORD 3'h5
// Target classes
`define BSBX_CL_RAM 2'h0
`define BSBX_CL_PORT 2'h1
`define BSBX_CL_SFR 2'h2
// Branch conditions
`define BSBX_C_CY 4'h0
`define BSBX_C_NCY 4'h1
`define BSBX_C_EQ 4'h2
`define BSBX_C_NE 4'h3
`define BSBX_C_UGT 4'h4
`define BSBX_C_ULE 4'h5
`define BSBX_C_SLT 4'h6
`define BSBX_C_SLE 4'h7
`define BSBX_C_SGT 4'h8
`define BSBX_C_SGE 4'h9
// Extra states for port and SPECIAL_FUNCTION_REGISTER targets, and for odd internal branch targets
`define BSBX_X_RD_PORT 4'h1
`define BSBX_X_RD_SFR 4'h2
`define BSBX_X_WR_PORT 4'h2
`define BSBX_X_WR_SFR 4'h3
`define BSBX_X_ODD 4'h1
// Branch taken penalty over not-taken
`define BSBX_X_TAKEN 4'h3
`endif

//--- rtl/bsbx_cond.v
// Branch condition evaluation from status flags
`default_nettype none
module bsbx_cond (
  input wire [3:0] cond_i,
  input wire carry_i,
  input wire zero_i,
  input wire negative_i,
  input wire overflow_i,
  output reg take_o,
  output reg bad_o
);
`include "bsbx_regs.vh"
  wire lt_s = negative_i ^ overflow_i;
  // Customary flag tests
  always @*
  begin
    bad_o = 1'b0;
    case (cond_i)
      `BSBX_C_CY: take_o = carry_i;
      `BSBX_C_NCY: take_o = ~carry_i;
      `BSBX_C_EQ: take_o = zero_i;
      `BSBX_C_NE: take_o = ~zero_i;
      `BSBX_C_UGT: take_o = ~carry_i & ~zero_i;
      `BSBX_C_ULE: take_o = carry_i | zero_i;
      `BSBX_C_SLT: take_o = lt_s;
      `BSBX_C_SLE: take_o = lt_s | zero_i;
      `BSBX_C_SGT: take_o = ~(lt_s | zero_i);
      `BSBX_C_SGE: take_o = ~lt_s;
      default:
      begin
        take_o = 1'b0;
        bad_o = 1'b1;
      end
    endcase
  end
endmodule
`default_nettype wire

//--- rtl/bsbx_timing.v
// Byte length and state count per operation and mode
`default_nettype none
module bsbx_timing (
  input wire [4:0] op_i,
  input wire [2:0] form_i,
  input wire [3:0] cond_i,
  input wire src_i,
  input wire [1:0] cls_i,
  input wire taken_i,
  output reg [3:0] states_o,
  output reg [2:0] bytes_o,
  output reg bad_o
);
`include "bsbx_regs.vh"
  reg [3:0] xr;
  reg [3:0] xw;
  // Port and SPECIAL_FUNCTION_REGISTER penalties, read and write kinds
  always @*
  begin
    xr = 4'h0;
    xw = 4'h0;
    if (cls_i == `BSBX_CL_PORT)
    begin
      xr = `BSBX_X_RD_PORT;
      xw = `BSBX_X_WR_PORT;
    end
    else if (cls_i == `BSBX_CL_SFR)
    begin
      xr = `BSBX_X_RD_SFR;
      xw = `BSBX_X_WR_SFR;
    end
  end
  // Base table
  always @*
  begin
    states_o = 4'h1;
    bytes_o = 3'h1;
    bad_o = 1'b0;
    case (op_i)
      `BSBX_OP_CLR_C, `BSBX_OP_SET_C, `BSBX_OP_CPL_C: ;
      `BSBX_OP_ANL, `BSBX_OP_ANL_N, `BSBX_OP_ORL, `BSBX_OP_ORL_N,
      `BSBX_OP_MOV_CB:
        if (form_i == `BSBX_F_SHORT)
        begin
          states_o = 4'h1 + xr;
          bytes_o = 3'h2;
        end
        else
        begin
          states_o = (src_i ? 4'h2 : 4'h3) + xr;
          bytes_o = src_i ? 3'h3 : 3'h4;
          bad_o = form_i != `BSBX_F_LONG;
        end
      `BSBX_OP_CLR_B, `BSBX_OP_SET_B, `BSBX_OP_CPL_B,
      `BSBX_OP_MOV_BC:
        if (form_i == `BSBX_F_SHORT)
        begin
          states_o = 4'h2 + xw;
          bytes_o = 3'h2;
        end
        else
        begin
          states_o = (src_i ? 4'h3 : 4'h4) + xw;
          bytes_o = src_i ? 3'h3 : 3'h4;
          bad_o = form_i != `BSBX_F_LONG;
        end
      `BSBX_OP_XCH, `BSBX_OP_NIBBLE_SWAP_OP:
        case (form_i)
          `BSBX_F_REG:
          begin
            states_o = src_i ? 4'h4 : 4'h3;
            bytes_o = src_i ? 3'h2 : 3'h1;
            bad_o = op_i == `BSBX_OP_NIBBLE_SWAP_OP;
          end
          `BSBX_F_DIR:
          begin
            states_o = 4'h3 + xw;
            bytes_o = 3'h2;
            bad_o = op_i == `BSBX_OP_NIBBLE_SWAP_OP;
          end
          `BSBX_F_IND:
          begin
            states_o = src_i ? 4'h5 : 4'h4;
            bytes_o = src_i ? 3'h2 : 3'h1;
          end
          default: bad_o = 1'b1;
        endcase
      `BSBX_OP_PUSH, `BSBX_OP_POP:
      begin
        bytes_o = src_i ? 3'h2 : 3'h3;
        case (form_i)
          `BSBX_F_SDIR:
          begin
            states_o = (op_i == `BSBX_OP_PUSH ? 4'h2 : 4'h3) + xr;
            bytes_o = 3'h2;
          end
          `BSBX_F_IMM8:
          begin
            states_o = src_i ? 4'h3 : 4'h4;
            bytes_o = src_i ? 3'h3 : 3'h4;
            bad_o = op_i == `BSBX_OP_POP;
          end
          `BSBX_F_IMM16:
          begin
            states_o = 4'h5;
            bytes_o = src_i ? 3'h4 : 3'h5;
            bad_o = op_i == `BSBX_OP_POP;
          end
          `BSBX_F_BYTE:
            states_o = (op_i == `BSBX_OP_PUSH ? 4'h4 : 4'h3) - {3'h0, src_i};
          `BSBX_F_WORD: states_o = src_i ? 4'h4 : 4'h5;
          `BSBX_F_DWORD: states_o = src_i ? 4'h8 : 4'h9;
          default: bad_o = 1'b1;
        endcase
      end
      `BSBX_OP_BR:
      begin
        // Carry branches are short in both modes
        if (cond_i <= `BSBX_C_NCY || src_i)
        begin
          states_o = 4'h1;
          bytes_o = 3'h2;
        end
        else
        begin
          states_o = 4'h2;
          bytes_o = 3'h3;
        end
        if (taken_i)
          states_o = states_o + `BSBX_X_TAKEN;
      end
      default: bad_o = 1'b1;
    endcase
  end
endmodule
`default_nettype wire

//--- rtl/bsbx_exec.v
// Bit, exchange, stack and conditional branch execution slice
`default_nettype none
module bsbx_exec (
  input wire ref_clk_i,
  input wire reset_i,
  input wire start_i,
  input wire [4:0] op_i,
  input wire [2:0] form_i,
  input wire [3:0] cond_i,
  input wire source_mode_i,
  input wire [1:0] target_class_i,
  input wire internal_exec_i,
  input wire target_internal_i,
  input wire carry_i,
  input wire zero_i,
  input wire negative_i,
  input wire overflow_i,
  input wire bit_i,
  input wire [7:0] accumulator_i,
  input wire [31:0] operand_i,
  input wire [15:0] stack_pointer_i,
  input wire [15:0] pc_i,
  input wire [7:0] rel_i,
  output reg busy_o,
  output reg done_o,
  output reg illegal_o,
  output reg carry_o,
  output reg carry_wr_o,
  output reg bit_value_o,
  output reg bit_wr_o,
  output reg [7:0] accumulator_o,
  output reg acc_wr_o,
  output reg [31:0] result_o,
  output reg result_wr_o,
  output reg [15:0] stack_pointer_o,
  output reg [15:0] stack_addr_o,
  output reg stack_wr_o,
  output reg stack_rd_o,
  output reg [15:0] pc_o,
  output reg branch_taken_o,
  output reg [2:0] length_o,
  output reg [3:0] states_o
);
`include "bsbx_regs.vh"
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;

  reg state_reg;
  reg [3:0] cnt_reg;
  reg [4:0] op_reg;
  reg [2:0] form_reg;
  reg carry_reg;
  reg bit_reg;
  reg [7:0] acc_reg;
  reg [31:0] opnd_reg;
  reg [15:0] sp_reg;
  reg [15:0] tgt_reg;
  reg [15:0] next_pc_reg;
  reg take_reg;

  wire take;
  wire cond_bad;
  wire [3:0] base_states;
  wire [2:0] bytes;
  wire time_bad;

  bsbx_cond u_cond (
    .cond_i(cond_i),
    .carry_i(carry_i),
    .zero_i(zero_i),
    .negative_i(negative_i),
    .overflow_i(overflow_i),
    .take_o(take),
    .bad_o(cond_bad)
  );

  wire is_br = op_i == `BSBX_OP_BR;
  wire br_take = is_br & take & ~cond_bad;

  bsbx_timing u_timing (
    .op_i(op_i),
    .form_i(form_i),
    .cond_i(cond_i),
    .src_i(source_mode_i),
    .cls_i(target_class_i),
    .taken_i(br_take),
    .states_o(base_states),
    .bytes_o(bytes),
    .bad_o(time_bad)
  );

  // Branch target: following address plus signed offset
  wire [15:0] next_pc = pc_i + {13'h0000, bytes};
  wire [15:0] target = next_pc + {{8{rel_i[7]}}, rel_i};
  // Odd internal target penalty on taken branches
  wire odd_pen = br_take & internal_exec_i & target_internal_i
    & target[0];
  wire [3:0] total = base_states + (odd_pen ? `BSBX_X_ODD : 4'h0);
  wire bad = time_bad | (is_br & cond_bad);

  // Operand size for stack moves, in bytes
  reg [15:0] size;
  always @*
  begin
    case (form_reg)
      `BSBX_F_IMM16, `BSBX_F_WORD: size = 16'h0002;
      `BSBX_F_DWORD: size = 16'h0004;
      default: size = 16'h0001;
    endcase
  end

  // Results from the latched operands
  reg c_n;
  reg c_we;
  reg b_n;
  reg b_we;
  reg [7:0] a_n;
  reg a_we;
  reg [31:0] r_n;
  reg r_we;
  reg [15:0] sp_n;
  reg [15:0] sa_n;
  reg s_wr;
  reg s_rd;
  always @*
  begin
    c_n = carry_reg;
    c_we = 1'b0;
    b_n = bit_reg;
    b_we = 1'b0;
    a_n = acc_reg;
    a_we = 1'b0;
    r_n = opnd_reg;
    r_we = 1'b0;
    sp_n = sp_reg;
    sa_n = sp_reg;
    s_wr = 1'b0;
    s_rd = 1'b0;
    case (op_reg)
      `BSBX_OP_CLR_C:
      begin
        c_n = 1'b0;
        c_we = 1'b1;
      end
      `BSBX_OP_SET_C:
      begin
        c_n = 1'b1;
        c_we = 1'b1;
      end
      `BSBX_OP_CPL_C:
      begin
        c_n = ~carry_reg;
        c_we = 1'b1;
      end
      `BSBX_OP_CLR_B:
      begin
        b_n = 1'b0;
        b_we = 1'b1;
      end
      `BSBX_OP_SET_B:
      begin
        b_n = 1'b1;
        b_we = 1'b1;
      end
      `BSBX_OP_CPL_B:
      begin
        b_n = ~bit_reg;
        b_we = 1'b1;
      end
      `BSBX_OP_ANL, `BSBX_OP_ANL_N:
      begin
        c_n = carry_reg & (bit_reg ^ op_reg[0]);
        c_we = 1'b1;
      end
      `BSBX_OP_ORL, `BSBX_OP_ORL_N:
      begin
        c_n = carry_reg | (bit_reg ^ op_reg[0]);
        c_we = 1'b1;
      end
      `BSBX_OP_MOV_CB:
      begin
        c_n = bit_reg;
        c_we = 1'b1;
      end
      `BSBX_OP_MOV_BC:
      begin
        b_n = carry_reg;
        b_we = 1'b1;
      end
      `BSBX_OP_XCH:
      begin
        a_n = opnd_reg[7:0];
        r_n = {24'h000000, acc_reg};
        a_we = 1'b1;
        r_we = 1'b1;
      end
      `BSBX_OP_NIBBLE_SWAP_OP:
      begin
        a_n = {acc_reg[7:4], opnd_reg[3:0]};
        r_n = {24'h000000, opnd_reg[7:4], acc_reg[3:0]};
        a_we = 1'b1;
        r_we = 1'b1;
      end
      `BSBX_OP_PUSH:
      begin
        sa_n = sp_reg + 16'h0001;
        sp_n = sa_n + size - 16'h0001;
        s_wr = 1'b1;
      end
      `BSBX_OP_POP:
      begin
        sa_n = sp_reg - size + 16'h0001;
        sp_n = sa_n - 16'h0001;
        s_rd = 1'b1;
        r_we = 1'b1;
      end
      default: ;
    endcase
  end

  // Sequencer: one clock per documented state
  always @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      op_reg <= 5'h00;
      form_reg <= 3'h0;
      carry_reg <= 1'b0;
      bit_reg <= 1'b0;
      acc_reg <= 8'h00;
      opnd_reg <= 32'h00000000;
      sp_reg <= 16'h0000;
      tgt_reg <= 16'h0000;
      next_pc_reg <= 16'h0000;
      take_reg <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      illegal_o <= 1'b0;
      carry_o <= 1'b0;
      carry_wr_o <= 1'b0;
      bit_value_o <= 1'b0;
      bit_wr_o <= 1'b0;
      accumulator_o <= 8'h00;
      acc_wr_o <= 1'b0;
      result_o <= 32'h00000000;
      result_wr_o <= 1'b0;
      stack_pointer_o <= 16'h0000;
      stack_addr_o <= 16'h0000;
      stack_wr_o <= 1'b0;
      stack_rd_o <= 1'b0;
      pc_o <= 16'h0000;
      branch_taken_o <= 1'b0;
      length_o <= 3'h0;
      states_o <= 4'h0;
    end
    else
    begin
      // Strobes last one cycle
      done_o <= 1'b0;
      carry_wr_o <= 1'b0;
      bit_wr_o <= 1'b0;
      acc_wr_o <= 1'b0;
      result_wr_o <= 1'b0;
      stack_wr_o <= 1'b0;
      stack_rd_o <= 1'b0;
      case (state_reg)
        ST_IDLE:
          if (start_i)
          begin
            state_reg <= ST_RUN;
            busy_o <= 1'b1;
            cnt_reg <= total - 4'h1;
            op_reg <= bad ? 5'h1f : op_i;
            form_reg <= form_i;
            carry_reg <= carry_i;
            bit_reg <= bit_i;
            acc_reg <= accumulator_i;
            opnd_reg <= operand_i;
            sp_reg <= stack_pointer_i;
            tgt_reg <= target;
            next_pc_reg <= next_pc;
            take_reg <= br_take;
            illegal_o <= bad;
            length_o <= bytes;
            states_o <= total;
          end
        ST_RUN:
          if (cnt_reg == 4'h0)
          begin
            state_reg <= ST_IDLE;
            busy_o <= 1'b0;
            done_o <= 1'b1;
            carry_o <= c_n;
            carry_wr_o <= c_we;
            bit_value_o <= b_n;
            bit_wr_o <= b_we;
            accumulator_o <= a_n;
            acc_wr_o <= a_we;
            result_o <= r_n;
            result_wr_o <= r_we;
            stack_pointer_o <= sp_n;
            stack_addr_o <= sa_n;
            stack_wr_o <= s_wr;
            stack_rd_o <= s_rd;
            pc_o <= take_reg ? tgt_reg : next_pc_reg;
            branch_taken_o <= take_reg;
          end
          else
            cnt_reg <= cnt_reg - 4'h1;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- verification/bsbx_exec_assertions.sv
// Port checker for the bit, stack and branch execution slice
`default_nettype none
`include "bsbx_regs.vh"
module bsbx_exec_assertions (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire logic [4:0] op_i,
  input wire logic [2:0] form_i,
  input wire logic [3:0] cond_i,
  input wire logic [1:0] target_class_i,
  input wire logic carry_i,
  input wire logic bit_i,
  input wire logic [15:0] stack_pointer_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic illegal_o,
  input wire logic carry_o,
  input wire logic carry_wr_o,
  input wire logic [15:0] stack_addr_o,
  input wire logic stack_wr_o,
  input wire logic branch_taken_o,
  input wire logic [2:0] length_o,
  input wire logic [3:0] states_o
);
  logic [4:0] op_reg;
  logic cy_reg;
  logic bit_reg;
  logic [15:0] sp_reg;
  logic [3:0] cnt_reg;
  wire take = start_i && !busy_o;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // Operands of the accepted request
  always_ff @(posedge ref_clk_i)
    if (take)
    begin
      op_reg <= op_i;
      cy_reg <= carry_i;
      bit_reg <= bit_i;
      sp_reg <= stack_pointer_i;
    end
  // Busy cycles of the running operation
  always_ff @(posedge ref_clk_i or posedge reset_i)
    if (reset_i)
      cnt_reg <= 4'h0;
    else
      cnt_reg <= busy_o ? cnt_reg + 4'h1 : 4'h0;
  property p_states;
    done_o && !illegal_o |-> !busy_o && cnt_reg == states_o;
  endproperty
  a_states: assert property (p_states) else $error("state count");
  property p_and;
    done_o && !illegal_o && op_reg inside {`BSBX_OP_ANL, `BSBX_OP_ANL_N}
      |-> carry_wr_o && carry_o == (cy_reg & (bit_reg ^ op_reg[0]));
  endproperty
  a_and: assert property (p_and) else $error("and carry");
  property p_or;
    done_o && !illegal_o && op_reg inside {`BSBX_OP_ORL, `BSBX_OP_ORL_N}
      |-> carry_wr_o && carry_o == (cy_reg | (bit_reg ^ op_reg[0]));
  endproperty
  a_or: assert property (p_or) else $error("or carry");
  property p_mov;
    done_o && !illegal_o && op_reg == `BSBX_OP_MOV_CB
      |-> carry_wr_o && carry_o == bit_reg;
  endproperty
  a_mov: assert property (p_mov) else $error("bit to carry");
  property p_short_read;
    take && op_i inside {[`BSBX_OP_ANL:`BSBX_OP_MOV_CB]} && form_i == 3'h0
      && target_class_i == 2'h0 |=> states_o == 4'h1 && length_o == 3'h2;
  endproperty
  a_short_read: assert property (p_short_read) else $error("short read");
  property p_carry_only;
    take && op_i <= `BSBX_OP_CPL_C && form_i == 3'h0
      |=> states_o == 4'h1 && length_o == 3'h1 ##1 done_o && carry_wr_o;
  endproperty
  a_carry_only: assert property (p_carry_only) else $error("carry op");
  property p_jc_not;
    take && op_i == `BSBX_OP_BR && cond_i == `BSBX_C_CY && !carry_i
      |=> states_o == 4'h1 && length_o == 3'h2 ##1 done_o && !branch_taken_o;
  endproperty
  a_jc_not: assert property (p_jc_not) else $error("carry branch");
  property p_jc_taken;
    take && op_i == `BSBX_OP_BR && cond_i == `BSBX_C_CY && carry_i
      |=> length_o == 3'h2 && (states_o == 4'h4 || states_o == 4'h5);
  endproperty
  a_jc_taken: assert property (p_jc_taken) else $error("carry taken");
  property p_push;
    stack_wr_o |-> stack_addr_o == sp_reg + 16'h1;
  endproperty
  a_push: assert property (p_push) else $error("push address");
  c_taken: cover property (done_o && branch_taken_o);
  c_push: cover property (stack_wr_o);
  c_illegal: cover property (done_o && illegal_o);
endmodule
bind bsbx_exec bsbx_exec_assertions u_bsbx_chk (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .start_i(start_i), .op_i(op_i),
  .form_i(form_i), .cond_i(cond_i), .target_class_i(target_class_i),
  .carry_i(carry_i), .bit_i(bit_i), .stack_pointer_i(stack_pointer_i),
  .busy_o(busy_o), .done_o(done_o), .illegal_o(illegal_o),
  .carry_o(carry_o), .carry_wr_o(carry_wr_o), .stack_addr_o(stack_addr_o),
  .stack_wr_o(stack_wr_o), .branch_taken_o(branch_taken_o),
  .length_o(length_o), .states_o(states_o)
);
`default_nettype wire

//--- verification/bsbx_exec_tb.sv
// Self-checking bench for the bit, stack and branch execution slice
`default_nettype none
`include "bsbx_regs.vh"
module bsbx_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [4:0] op;
    logic [2:0] fm;
    logic [3:0] cd;
    logic [1:0] cl;
    logic src, ie, ti, cy, zf, nf, vf, bi;
    logic [7:0] acc, rel;
    logic [31:0] opd;
    logic [15:0] sp, pc;
  } bsbx_in_t;
  typedef struct packed {
    logic [2:0] k;
    logic [3:0] st;
    logic [2:0] len;
    logic [63:0] v;
  } bsbx_exp_t;
  // Push and pop states, lengths and sizes, one nibble per form
  localparam logic [23:0] PUSH_BIN = 24'h954542;
  localparam logic [23:0] PUSH_SRC = 24'h843532;
  localparam logic [23:0] POP_BIN = 24'h953003;
  localparam logic [23:0] POP_SRC = 24'h842003;
  localparam logic [23:0] LEN_BIN = 24'h333542;
  localparam logic [23:0] SIZE_TAB = 24'h421211;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic start_i = 1'b0;
  bsbx_in_t cur = '0;
  bsbx_in_t nx;
  bsbx_exp_t q[$];
  bsbx_exp_t ex;
  logic busy, done, ill, co, cwr, bv, bwr, aw, rw, sw, sr, tk;
  logic [7:0] ao;
  logic [31:0] ro;
  logic [15:0] spo, sao, pco;
  logic [2:0] len;
  logic [3:0] st;
  logic [31:0] seed = 32'h00000035;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  bsbx_exec DUT (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .start_i(start_i),
    .op_i(cur.op), .form_i(cur.fm), .cond_i(cur.cd), .source_mode_i(cur.src),
    .target_class_i(cur.cl), .internal_exec_i(cur.ie),
    .target_internal_i(cur.ti), .carry_i(cur.cy), .zero_i(cur.zf),
    .negative_i(cur.nf), .overflow_i(cur.vf), .bit_i(cur.bi),
    .accumulator_i(cur.acc), .operand_i(cur.opd), .stack_pointer_i(cur.sp),
    .pc_i(cur.pc), .rel_i(cur.rel), .busy_o(busy), .done_o(done),
    .illegal_o(ill), .carry_o(co), .carry_wr_o(cwr), .bit_value_o(bv),
    .bit_wr_o(bwr), .accumulator_o(ao), .acc_wr_o(aw), .result_o(ro),
    .result_wr_o(rw), .stack_pointer_o(spo), .stack_addr_o(sao),
    .stack_wr_o(sw), .stack_rd_o(sr), .pc_o(pco), .branch_taken_o(tk),
    .length_o(len), .states_o(st)
  );
  initial
    forever #4 ref_clk_i = ~ref_clk_i;
  // Xorshift source of stimulus
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Fresh random operands, plain memory target
  function automatic bsbx_in_t rin();
    logic [127:0] r;
    r = {rnd(), rnd(), rnd(), rnd()};
    rin = r[101:0];
    rin.cl = 2'h0;
  endfunction
  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // One request; a start held into busy must be ignored
  task automatic issue(input bsbx_exp_t e, input logic hold);
    int n;
    n = 0;
    q.push_back(e);
    @(posedge ref_clk_i);
    cur <= nx;
    start_i <= 1'b1;
    @(posedge ref_clk_i);
    start_i <= hold;
    @(posedge ref_clk_i);
    start_i <= 1'b0;
    @(negedge ref_clk_i);
    while (busy === 1'b1 && n < 20)
    begin
      @(negedge ref_clk_i);
      n++;
    end
  endtask
  // Each done pulse is matched with the oldest expectation
  always @(negedge ref_clk_i)
    if (done === 1'b1)
    begin
      if (q.size() == 0)
        chk("spare done", 64'h0, 64'h1);
      else
      begin
        ex = q.pop_front();
        if (ex.st != 4'h0)
          chk("timing", 64'({ex.st, ex.len}), 64'({st, len}));
        case (ex.k)
          3'h0: chk("carry", ex.v, 64'({cwr, co}));
          3'h1: chk("bit", ex.v, 64'({bwr, bv}));
          3'h2: chk("swap", ex.v, 64'({aw, rw, ao, ro[7:0]}));
          3'h3: chk("branch", ex.v, 64'({tk, pco}));
          3'h4: chk("push", ex.v, 64'({sw, sao, spo}));
          3'h5: chk("pop", ex.v, 64'({sr, sao, spo, ro[7:0]}));
          default: chk("refused", ex.v, 64'({ill, cwr, bwr, aw, rw, sw, sr}));
        endcase
      end
    end
  // Cycle ceiling cuts a hang short
  always @(posedge ref_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  initial
  begin
    bsbx_exp_t e;
    logic c;
    logic w;
    logic s;
    logic [3:0] x;
    logic [2:0] l;
    logic [15:0] t;
    logic [23:0] tab;
    int j;
    int f;
    nx = '0;
    repeat (2) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    // Carry and bit operations over forms, modes and classes
    for (int i = 0; i < 60; i++)
    begin
      j = i % 12;
      nx = rin();
      nx.op = 5'(j);
      nx.fm = j < 3 ? 3'h0 : 3'(nx.rel[0]);
      nx.cl = j < 3 ? 2'h0 : 2'(nx.rel[2:1] % 2'h3);
      case (j)
        0, 3: c = 1'b0;
        1, 4: c = 1'b1;
        2: c = !nx.cy;
        5: c = !nx.bi;
        6: c = nx.cy & nx.bi;
        7: c = nx.cy & !nx.bi;
        8: c = nx.cy | nx.bi;
        9: c = nx.cy | !nx.bi;
        10: c = nx.bi;
        default: c = nx.cy;
      endcase
      w = j inside {3, 4, 5, 11};
      x = nx.fm[0] ? (nx.src ? 4'h2 : 4'h3) : 4'h1;
      x = x + 4'(w) + 4'(nx.cl) + 4'(w && nx.cl != 2'h0);
      l = nx.fm[0] ? (nx.src ? 3'h3 : 3'h4) : 3'h2;
      if (j < 3)
        issue('{3'h0, 4'h1, 3'h1, 64'({1'b1, c})}, 1'b0);
      else
        issue('{3'(w), x, l, 64'({1'b1, c})}, 1'b0);
    end
    $display("bit tests finished");
    // Accumulator exchange in every form
    for (int i = 0; i < 16; i++)
    begin
      j = i % 4;
      nx = rin();
      nx.op = j == 3 ? `BSBX_OP_NIBBLE_SWAP_OP : `BSBX_OP_XCH;
      nx.fm = j == 3 ? `BSBX_F_IND : 3'(j);
      nx.cl = j == 1 ? 2'(i % 3) : 2'h0;
      x = j == 1 ? 4'h3 + 4'(nx.cl) + 4'(nx.cl != 2'h0)
                 : (j == 0 ? 4'h3 : 4'h4) + 4'(nx.src);
      l = j == 1 || nx.src ? 3'h2 : 3'h1;
      e = '{3'h2, x, l, 64'({2'b11, nx.opd[7:0], nx.acc})};
      if (j == 3)
        e.v = 64'({2'b11, nx.acc[7:4], nx.opd[3:0], nx.opd[7:4], nx.acc[3:0]});
      issue(e, 1'b0);
    end
    $display("exchange tests finished");
    // Push in every form, pop in every form but the two immediate ones; the long push also sees a held start
    for (int i = 0; i < 30; i++)
    begin
      j = i % 10;
      f = j < 6 ? j : (j == 6 ? 0 : j - 4);
      nx = rin();
      nx.op = j < 6 ? `BSBX_OP_PUSH : `BSBX_OP_POP;
      nx.fm = 3'(f);
      nx.cl = f == 0 ? 2'(i % 3) : 2'h0;
      tab = j < 6 ? (nx.src ? PUSH_SRC : PUSH_BIN)
                  : (nx.src ? POP_SRC : POP_BIN);
      x = tab[4 * f +: 4] + 4'(nx.cl);
      l = LEN_BIN[4 * f +: 3] - 3'(nx.src && f != 0);
      t = 16'(SIZE_TAB[4 * f +: 4]);
      e = '{3'h4, x, l, 64'({1'b1, nx.sp + 16'h1, nx.sp + t})};
      if (j >= 6)
        e = '{3'h5, x, l, 64'({1'b1, nx.sp - t + 16'h1, nx.sp - t,
                                 nx.opd[7:0]})};
      issue(e, j == 5);
    end
    $display("stack tests finished");
    // Every status condition, odd internal targets included
    for (int i = 0; i < 80; i++)
    begin
      j = i % 10;
      nx = rin();
      nx.op = `BSBX_OP_BR;
      nx.cd = 4'(j);
      s = nx.nf ^ nx.vf;
      case (j)
        0: c = nx.cy;
        1: c = !nx.cy;
        2: c = nx.zf;
        3: c = !nx.zf;
        4: c = !nx.cy && !nx.zf;
        5: c = nx.cy || nx.zf;
        6: c = s;
        7: c = s || nx.zf;
        8: c = !(s || nx.zf);
        default: c = !s;
      endcase
      l = j > 1 && !nx.src ? 3'h3 : 3'h2;
      t = nx.pc + 16'(l) + {{8{nx.rel[7]}}, nx.rel};
      x = (j > 1 && !nx.src ? 4'h2 : 4'h1)
          + (c ? 4'h3 + 4'(nx.ie && nx.ti && t[0]) : 4'h0);
      e = '{3'h3, x, l, 64'({c, c ? t : nx.pc + 16'(l)})};
      issue(e, 1'b0);
    end
    $display("branch tests finished");
    // Unsupported combinations run without any write
    for (int i = 0; i < 3; i++)
    begin
      nx = rin();
      nx.op = i == 0 ? `BSBX_OP_NIBBLE_SWAP_OP : (i == 1 ? `BSBX_OP_BR : `BSBX_OP_POP);
      nx.fm = i == 0 ? `BSBX_F_REG : `BSBX_F_IMM8;
      nx.cd = 4'hf;
      issue('{3'h6, 4'h0, 3'h0, 64'h40}, 1'b0);
    end
    $display("refusal tests finished");
    repeat (4) @(posedge ref_clk_i);
    chk("pending", 64'h0, 64'(q.size()));
    give_verdict();
  end
endmodule
`default_nettype wire
